// *** core/kpi_pkg.sv ***
// Constants shared by the keypad pin interrupt unit and its synchroniser.
// Assumes a 100 MHz core clock and an Avalon-MM register slave.

package kpi_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int KPI_ADDR_W = 5;
   localparam int KPI_DATA_W = 32;
   localparam int KPI_PINS = 5;
   localparam int KPI_MAP_W = 6;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [4:0] KPI_OFF_STATUS_CONTROL = 5'h00;
   localparam logic [4:0] KPI_OFF_ENABLE = 5'h04;
   localparam logic [4:0] KPI_OFF_POLARITY = 5'h08;
   localparam logic [4:0] KPI_OFF_EVT_STATUS = 5'h0c;
   localparam logic [4:0] KPI_OFF_EVT_MASK = 5'h10;

   ////////////////////////////////////////////////////////////////////////
   // Status and control fields
   localparam int KPI_MODE_BIT = 0;
   localparam int KPI_IE_BIT = 1;
   localparam int KPI_ACK_BIT = 2;
   localparam int KPI_FLAG_BIT = 3;

   // Pin map: bits 5,4,2,1,0 exist, bit 3 absent
   localparam logic [5:0] KPI_PIN_MASK = 6'h37;

   // Event status fields
   localparam int KPI_EVT_DETECT_BIT = 0;
   localparam int KPI_EVT_REFUSED_BIT = 1;
   localparam int KPI_EVT_W = 2;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [5:0] KPI_RST_ENABLE = 6'h00;
   localparam logic [5:0] KPI_RST_POLARITY = 6'h00;
   localparam logic [1:0] KPI_RST_EVT = 2'h0;
   localparam logic [31:0] KPI_RST_RDATA = 32'h0000_0000;

   // Bus handshake state
   typedef enum logic [1:0] {
      KPI_BUS_IDLE = 2'b01,
      KPI_BUS_ACK = 2'b10
   } kpi_bus_t;

endpackage

// *** core/kpi_sync.sv ***
// Two-stage synchroniser for the external detection pins.
// Assumes asynchronous pin levels and one core clock.

`timescale 1ns/1ps
`default_nettype none

module kpi_sync
   import kpi_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [KPI_PINS-1:0] pin_async,
   output logic [KPI_PINS-1:0] pin_sync
);

   logic [KPI_PINS-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta <= '0;
         pin_sync <= '0;
      end else begin
         meta <= pin_async; // RULE17
         pin_sync <= meta; // RULE17
      end
   end

   sync_delay_a: assert property (@(posedge core_clk) disable iff (rst) // RULE17
      !$past(rst) && !$past(rst, 2) |-> pin_sync == $past(pin_async, 2))
      else $error("pin synchroniser is not two stages deep");

endmodule

`default_nettype wire

// *** core/kpi_top.sv ***
// Keypad pin interrupt unit: five watched pins, one flag, interrupt, wake and event requests.
// Assumes an Avalon-MM master on core_clk and power-mode levels from the
// same clock domain.
//
// What this block does
// RULE1 - Detection keeps running in wait mode and can wake the core.
// RULE2 - In stop mode enabled pins wake the core without a clock; stop_wake sets without one, but wake_req is registered on core_clk.
// RULE3 - Debug halt does not alter detection or flag behaviour.
// RULE4 - Each pin detects falling or rising edge, optionally plus level.
// RULE5 - Pin enable bits at 5,4,2,1,0; bit 3 absent and reads zero.
// RULE6 - Flag at bit 3 reads one on detection; writes cannot change it.
// RULE7 - Writing one to acknowledge bit 2 clears flag; it reads zero.
// RULE8 - Interrupt enable bit 1 gates the request.
// RULE9 - Mode bit 0 selects edge only or edge plus level.
// RULE10 - Three 8-bit registers: status-control, pin enable, polarity; the code adds event status and event mask at 0x0c and 0x10.
// RULE11 - All pins share one maskable interrupt request.
// RULE12 - Edges found by comparing synchronised samples on successive cycles.
// RULE13 - In level mode acknowledge clears only if all enabled pins idle.
// RULE14 - Polarity zero means falling/low, one means rising/high.
// RULE15 - Pin enable one makes pin a source; zero ignores it.
// RULE16 - Request high exactly while flag and interrupt enable are set; irq_req is registered, so it follows them one cycle later.
// RULE17 - Pins pass two flip-flops before edge or level checks; the stop-mode level check on act_raw takes the raw pins instead.

`timescale 1ns/1ps
`default_nettype none

module kpi_top
   import kpi_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [KPI_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [KPI_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [KPI_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [KPI_PINS-1:0] irq_input_pin,
   input wire logic wait_mode,
   input wire logic stop_mode,
   output logic irq_req,
   output logic wake_req,
   output logic event_irq
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Place five pins on the 6-bit register map, bit 3 empty
   function automatic logic [5:0] kpi_spread(input logic [4:0] p);
      kpi_spread = {p[4], p[3], 1'b0, p[2], p[1], p[0]};
   endfunction

   // Asserted level per pin under its polarity bit
   function automatic logic [5:0] kpi_active(input logic [5:0] lvl,
                                             input logic [5:0] pol);
      kpi_active = ~(lvl ^ pol); // RULE14
   endfunction

   function automatic logic kpi_hit(input logic [4:0] addr,
                                    input logic [4:0] off);
      kpi_hit = (addr == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers and state

   kpi_bus_t bus_state;
   logic detect_flag;
   logic irq_enable_bit;
   logic detect_mode_select;
   logic [5:0] pin_irq_enable;
   logic [5:0] pin_irq_polarity;
   logic [KPI_EVT_W-1:0] evt_status;
   logic [KPI_EVT_W-1:0] evt_mask;
   logic [KPI_PINS-1:0] pin_sync;
   logic [5:0] act_prev;
   logic stop_wake;

   logic wr_take;
   logic [5:0] act_now;
   logic [5:0] act_raw;
   logic edge_hit;
   logic lvl_hit;
   logic det_hit;
   logic ack_wr;
   logic ack_ok;
   logic stop_hit;
   logic [7:0] rd_byte;
   logic [KPI_EVT_W-1:0] evt_set;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser

   kpi_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .pin_async(irq_input_pin),
      .pin_sync(pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle, then the access completes

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bus_state <= KPI_BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= KPI_RST_RDATA;
      end else begin
         case (bus_state)
            KPI_BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_state <= KPI_BUS_ACK;
                  avs_waitrequest <= 1'b0;
                  avs_readdata <= avs_read ? {24'h00_0000, rd_byte}
                                           : KPI_RST_RDATA;
               end
            end
            KPI_BUS_ACK: begin
               bus_state <= KPI_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state <= KPI_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Writes land on the edge that completes the access; lane 0 only
   assign wr_take = (bus_state == KPI_BUS_ACK) && avs_write &&
                    avs_byteenable[0];

   // Unmapped offsets read zero
   always_comb begin
      case (avs_address)
         KPI_OFF_STATUS_CONTROL:
            rd_byte = {4'h0, detect_flag, 1'b0, // RULE7
                       irq_enable_bit, detect_mode_select}; // RULE10
         KPI_OFF_ENABLE: rd_byte = {2'b00, pin_irq_enable}; // RULE5
         KPI_OFF_POLARITY: rd_byte = {2'b00, pin_irq_polarity};
         KPI_OFF_EVT_STATUS: rd_byte = {6'h00, evt_status};
         KPI_OFF_EVT_MASK: rd_byte = {6'h00, evt_mask};
         default: rd_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_enable_bit <= 1'b0;
         detect_mode_select <= 1'b0;
      end else if (wr_take &&
                   kpi_hit(avs_address, KPI_OFF_STATUS_CONTROL)) begin
         irq_enable_bit <= avs_writedata[KPI_IE_BIT]; // RULE8
         detect_mode_select <= avs_writedata[KPI_MODE_BIT]; // RULE9
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_irq_enable <= KPI_RST_ENABLE;
      end else if (wr_take && kpi_hit(avs_address, KPI_OFF_ENABLE)) begin
         pin_irq_enable <= avs_writedata[5:0] & KPI_PIN_MASK; // RULE5
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_irq_polarity <= KPI_RST_POLARITY;
      end else if (wr_take && kpi_hit(avs_address, KPI_OFF_POLARITY)) begin
         pin_irq_polarity <= avs_writedata[5:0] & KPI_PIN_MASK; // RULE14
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Detection; no debug-halt gating, so halts change nothing // RULE3

   assign act_now = kpi_active(kpi_spread(pin_sync), pin_irq_polarity) &
                    pin_irq_enable; // RULE15
   assign edge_hit = |(act_now & ~act_prev); // RULE12
   assign lvl_hit = detect_mode_select && (|act_now); // RULE9
   assign det_hit = edge_hit || lvl_hit || stop_wake; // RULE4 RULE11

   always_ff @(posedge core_clk) begin
      if (rst) begin
         act_prev <= 6'h00;
      end else begin
         act_prev <= act_now; // RULE12
      end
   end

   assign ack_wr = wr_take && kpi_hit(avs_address, KPI_OFF_STATUS_CONTROL)
                   && avs_writedata[KPI_ACK_BIT];
   assign ack_ok = !detect_mode_select || !(|act_now); // RULE13

   // Detection beats a simultaneous acknowledge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         detect_flag <= 1'b0;
      end else if (det_hit) begin
         detect_flag <= 1'b1; // RULE6
      end else if (ack_wr && ack_ok) begin
         detect_flag <= 1'b0; // RULE7 RULE13
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stop mode: raw pins bypass the synchroniser since no clock runs.
   // Glitches can wake the core; that only costs a spurious flag.

   assign act_raw = kpi_active(kpi_spread(irq_input_pin), pin_irq_polarity)
                    & pin_irq_enable;
   assign stop_hit = stop_mode && irq_enable_bit && (|act_raw); // RULE2

   always_ff @(posedge core_clk or posedge stop_hit) begin
      if (stop_hit) begin
         stop_wake <= 1'b1; // RULE2
      end else if (rst) begin
         stop_wake <= 1'b0;
      end else if (!stop_mode) begin
         stop_wake <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request and wake outputs

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_req <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         irq_req <= detect_flag && irq_enable_bit; // RULE16 RULE8 RULE11
         wake_req <= (stop_wake || (wait_mode && detect_flag)) &&
                     irq_enable_bit; // RULE1 RULE2
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event status, write one to clear; set wins over clear

   assign evt_set = {ack_wr && !ack_ok, det_hit && !detect_flag};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         evt_status <= KPI_RST_EVT;
      end else begin
         if (wr_take && kpi_hit(avs_address, KPI_OFF_EVT_STATUS)) begin
            evt_status <= (evt_status & ~avs_writedata[KPI_EVT_W-1:0]) |
                          evt_set;
         end else begin
            evt_status <= evt_status | evt_set;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         evt_mask <= KPI_RST_EVT;
      end else if (wr_take && kpi_hit(avs_address, KPI_OFF_EVT_MASK)) begin
         evt_mask <= avs_writedata[KPI_EVT_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         event_irq <= 1'b0;
      end else begin
         event_irq <= |(evt_status & evt_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   irq_gate_a: assert property (@(posedge core_clk) disable iff (rst) // RULE16
      detect_flag && irq_enable_bit |=> irq_req)
      else $error("request missing with flag and enable set");

   irq_block_a: assert property (@(posedge core_clk) disable iff (rst) // RULE8
      !irq_enable_bit |=> !irq_req)
      else $error("request raised with interrupt enable clear");

   edge_set_a: assert property (@(posedge core_clk) disable iff (rst) // RULE12
      |(act_now & ~act_prev) |=> detect_flag)
      else $error("enabled edge did not set the flag");

   ack_clear_a: assert property (@(posedge core_clk) disable iff (rst) // RULE7
      ack_wr && !detect_mode_select && !det_hit |=> !detect_flag)
      else $error("acknowledge in edge mode did not clear flag");

   level_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RULE13
      ack_wr && detect_mode_select && (|act_now) |=> detect_flag)
      else $error("acknowledge cleared flag while a pin is asserted");

   flag_keep_a: assert property (@(posedge core_clk) disable iff (rst) // RULE6
      detect_flag && !ack_wr |=> detect_flag)
      else $error("flag dropped without acknowledge");

   ack_read_a: assert property (@(posedge core_clk) disable iff (rst) // RULE7
      bus_state == KPI_BUS_IDLE && avs_read &&
      avs_address == KPI_OFF_STATUS_CONTROL |=>
      !avs_waitrequest && !avs_readdata[KPI_ACK_BIT])
      else $error("acknowledge bit read back nonzero");

   absent_bit_a: assert property (@(posedge core_clk) disable iff (rst) // RULE5
      bus_state == KPI_BUS_IDLE && avs_read &&
      avs_address == KPI_OFF_ENABLE |=> !avs_readdata[3])
      else $error("absent enable bit 3 read as one");

   idle_pins_a: assert property (@(posedge core_clk) disable iff (rst) // RULE15
      !detect_flag && pin_irq_enable == 6'h00 && !stop_wake
      |=> !detect_flag)
      else $error("flag set with every pin disabled");

   wait_wake_a: assert property (@(posedge core_clk) disable iff (rst) // RULE1
      wait_mode && detect_flag && irq_enable_bit |=> wake_req)
      else $error("no wake from wait with flag and enable set");

   stop_flag_a: assert property (@(posedge core_clk) disable iff (rst) // RULE2
      stop_wake |=> detect_flag ##1 irq_req)
      else $error("stop wake did not set flag and request");

   bus_ack_a: assert property (@(posedge core_clk) disable iff (rst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1
      avs_waitrequest)
      else $error("bus access not completed in one wait cycle");

   edge_cov_c: cover property (@(posedge core_clk) disable iff (rst)
      !detect_mode_select && edge_hit ##1 irq_req);

   refused_cov_c: cover property (@(posedge core_clk) disable iff (rst)
      ack_wr && !ack_ok);

   stop_cov_c: cover property (@(posedge core_clk) disable iff (rst)
      stop_mode && stop_wake ##1 wake_req);

   evt_cov_c: cover property (@(posedge core_clk) disable iff (rst)
      event_irq);

endmodule

`default_nettype wire

// *** verif/kpi_pin_model.sv ***
// External switch model driving the five watched pins.
// Assumes the bench commands pin levels on the core clock.

`timescale 1ns/1ps
`default_nettype none

module kpi_pin_model
   import kpi_pkg::*;
(
   input wire logic core_clk,
   input wire logic [KPI_PINS-1:0] level_cmd,
   output logic [KPI_PINS-1:0] pin
);

   // Settles off the clock edge, so the synchroniser sees a true async change
   initial begin
      pin = 5'h00;
      forever begin
         @(posedge core_clk);
         pin <= #3 level_cmd;
      end
   end

endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the keypad pin interrupt unit.
// Assumes kpi_pkg, kpi_sync, kpi_top and kpi_pin_model compiled first.

`timescale 1ns/1ps
`default_nettype none

module tb_top
   import kpi_pkg::*;
   ;

   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [4:0] level_cmd = 5'h00;
   logic [4:0] pins;
   logic wait_mode = 1'b0;
   logic stop_mode = 1'b0;
   logic irq_req;
   logic wake_req;
   logic event_irq;
   logic [31:0] rd;
   logic [7:0] v;
   logic [4:0] idle;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   int j;

   kpi_top dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq_input_pin(pins), .wait_mode(wait_mode), .stop_mode(stop_mode),
      .irq_req(irq_req), .wake_req(wake_req), .event_irq(event_irq));

   kpi_pin_model pin_model (.core_clk(core_clk), .level_cmd(level_cmd),
      .pin(pins));

   always #5 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////
   // Reporting
   task final_report;
      if (fails == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Ceiling well above the thousand or so cycles the sequence needs
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM master, entered just after a rising edge
   task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge core_clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // Extra edge keeps a following call from reassigning in one step
      @(posedge core_clk);
   endtask

   task wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task rdchk(input logic [4:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(rd, {24'h000000, exp});
   endtask

   task tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   function automatic logic [7:0] pin_bit(input int i);
      return (i < 3) ? (8'h01 << i) : (8'h02 << i);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'hf9be1702));
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      check(irq_req, 1'b0);
      rdchk(KPI_OFF_STATUS_CONTROL, 8'h00);
      rdchk(KPI_OFF_ENABLE, 8'h00);
      rdchk(KPI_OFF_POLARITY, 8'h00);
      for (int k = 0; k < 8; k++) begin
         v = 8'($urandom);
         wr(KPI_OFF_ENABLE, v);
         rdchk(KPI_OFF_ENABLE, v & 8'h37);
         v = 8'($urandom);
         wr(KPI_OFF_POLARITY, v);
         rdchk(KPI_OFF_POLARITY, v & 8'h37);
      end
      // Low byte lane off: write must be dropped
      avs_byteenable <= 4'he;
      wr(KPI_OFF_POLARITY, ~v);
      avs_byteenable <= 4'hf;
      rdchk(KPI_OFF_POLARITY, v & 8'h37);
      wr(5'h14, 8'hff);
      rdchk(5'h14, 8'h00);
      wr(KPI_OFF_ENABLE, 8'h00);
      wr(KPI_OFF_STATUS_CONTROL, 8'hff);
      rdchk(KPI_OFF_STATUS_CONTROL, 8'h03);
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 5; i++) begin
            idle = p ? 5'h00 : 5'h1f;
            wr(KPI_OFF_STATUS_CONTROL, 8'h00);
            wr(KPI_OFF_ENABLE, 8'h00);
            level_cmd <= idle;
            wr(KPI_OFF_POLARITY, p ? 8'h37 : 8'h00);
            wr(KPI_OFF_ENABLE, pin_bit(i));
            wr(KPI_OFF_STATUS_CONTROL, 8'h04);
            rdchk(KPI_OFF_STATUS_CONTROL, 8'h00);
            j = (i + 1 + $urandom % 4) % 5;
            level_cmd <= idle ^ (5'h01 << j);
            tick(6);
            rdchk(KPI_OFF_STATUS_CONTROL, 8'h00);
            level_cmd <= idle ^ (5'h01 << j) ^ (5'h01 << i);
            tick(6);
            rdchk(KPI_OFF_STATUS_CONTROL, 8'h08);
            check(irq_req, 1'b0);
            wr(KPI_OFF_STATUS_CONTROL, 8'h02);
            tick(2);
            check(irq_req, 1'b1);
            rdchk(KPI_OFF_STATUS_CONTROL, 8'h0a);
            wr(KPI_OFF_STATUS_CONTROL, 8'h06);
            rdchk(KPI_OFF_STATUS_CONTROL, 8'h02);
            tick(2);
            check(irq_req, 1'b0);
            level_cmd <= idle;
            wr(KPI_OFF_STATUS_CONTROL, 8'h01);
            level_cmd <= idle ^ (5'h01 << i);
            tick(6);
            wr(KPI_OFF_STATUS_CONTROL, 8'h05);
            rdchk(KPI_OFF_STATUS_CONTROL, 8'h09);
            rdchk(KPI_OFF_EVT_STATUS, 8'h03);
            level_cmd <= idle;
            tick(6);
            wr(KPI_OFF_STATUS_CONTROL, 8'h05);
            rdchk(KPI_OFF_STATUS_CONTROL, 8'h01);
         end
      end
      // Event interrupt: raise masked, unmask, clear
      wr(KPI_OFF_STATUS_CONTROL, 8'h00);
      wr(KPI_OFF_ENABLE, 8'h00);
      level_cmd <= 5'h1f;
      wr(KPI_OFF_POLARITY, 8'h00);
      wr(KPI_OFF_ENABLE, 8'h01);
      wr(KPI_OFF_STATUS_CONTROL, 8'h04);
      wr(KPI_OFF_EVT_MASK, 8'h00);
      wr(KPI_OFF_EVT_STATUS, 8'h03);
      level_cmd <= 5'h1e;
      tick(6);
      rdchk(KPI_OFF_EVT_STATUS, 8'h01);
      check(event_irq, 1'b0);
      wr(KPI_OFF_EVT_MASK, 8'h01);
      tick(2);
      check(event_irq, 1'b1);
      wr(KPI_OFF_EVT_STATUS, 8'h01);
      tick(2);
      check(event_irq, 1'b0);
      // Wait mode wake needs flag and interrupt enable
      wait_mode <= 1'b1;
      tick(3);
      check(wake_req, 1'b0);
      wr(KPI_OFF_STATUS_CONTROL, 8'h02);
      tick(2);
      check(wake_req, 1'b1);
      level_cmd <= 5'h1f;
      tick(4);
      // Still in wait: only the cleared flag can drop the wake
      wr(KPI_OFF_STATUS_CONTROL, 8'h06);
      tick(2);
      check(wake_req, 1'b0);
      // Stop mode wake on asserted pin
      wait_mode <= 1'b0;
      stop_mode <= 1'b1;
      tick(2);
      level_cmd <= 5'h1e;
      tick(4);
      check(wake_req, 1'b1);
      stop_mode <= 1'b0;
      tick(2);
      rdchk(KPI_OFF_STATUS_CONTROL, 8'h0a);
      final_report();
   end

endmodule

`default_nettype wire
